// file: common/ccr_consts.svh
// Register offsets, field positions, reset values and timing counts of the comparator control.
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

`define CCR_AW 4
`define CCR_DW 8
`define CCR_OFS_CTRL 4'h0
`define CCR_OFS_PORT 4'h1

`define CCR_BIT_EN 7
`define CCR_BIT_RESULT 6
`define CCR_BIT_OE 5
`define CCR_BIT_POL 4
`define CCR_BIT_ZLF 3
`define CCR_BIT_SP 2
`define CCR_BIT_HYS 1
`define CCR_BIT_SYNC 0

`define CCR_CTRL_RESET 8'h04
`define CCR_RDATA_RESET 8'h00

`define CCR_CLK_PERIOD_NS 40
`define CCR_ZLF_HOLD_NS 20
`define CCR_ZLF_CW 4
`define CCR_ZLF_HOLD_CYC \
  (((`CCR_ZLF_HOLD_NS) / (`CCR_CLK_PERIOD_NS)) < 1 ? 1 : \
   ((`CCR_ZLF_HOLD_NS) / (`CCR_CLK_PERIOD_NS)))

`endif

// file: common/ccr_pkg.sv
// Types shared by the comparator control register block.
`include "ccr_consts.svh"

package ccr_pkg;

  typedef struct packed {
    logic en;
    logic oe;
    logic pol;
    logic zlf;
    logic sp;
    logic hys;
    logic sync;
  } ccr_ctrl_s;

  typedef struct packed {
    logic [`CCR_AW-1:0] addr;
    logic [`CCR_DW-1:0] wdata;
    logic wr;
    logic rd;
  } ccr_bus_s;

  typedef enum logic {
    CCR_ZLF_PASS,
    CCR_ZLF_HOLD
  } ccr_zlf_state_e;

endpackage

// file: hdl/ccr_zlf.sv
// Glitch filter that stops a fresh output change from reversing during a hold interval.
`timescale 1ns/1ps
`include "ccr_consts.svh"

module ccr_zlf (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control and data.
  input wire logic filter_en,
  input wire logic din,
  output logic dout_q
);
  import ccr_pkg::*;

  localparam logic [`CCR_ZLF_CW-1:0] HOLD_CYC = `CCR_ZLF_CW'(`CCR_ZLF_HOLD_CYC);

  ccr_zlf_state_e state_q;
  logic [`CCR_ZLF_CW-1:0] cnt_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CCR_ZLF_PASS;
      cnt_q <= '0;
      dout_q <= 1'b0;
    end else if (!filter_en) begin
      state_q <= CCR_ZLF_PASS;
      cnt_q <= '0;
      dout_q <= din;
    end else begin
      case (state_q)
        CCR_ZLF_PASS: begin
          // Take the change at once, then lock it for the hold interval.
          if (din != dout_q) begin
            dout_q <= din;
            cnt_q <= HOLD_CYC;
            state_q <= CCR_ZLF_HOLD;
          end
        end
        CCR_ZLF_HOLD: begin
          if (cnt_q <= `CCR_ZLF_CW'(1)) begin
            cnt_q <= '0;
            state_q <= CCR_ZLF_PASS;
          end else begin
            cnt_q <= cnt_q - `CCR_ZLF_CW'(1);
          end
        end
        default: begin
          state_q <= CCR_ZLF_PASS;
          cnt_q <= '0;
        end
      endcase
    end
  end

  a_zlf_no_reverse: assert property (@(posedge clk) disable iff (!reset_n)
    filter_en && $past(filter_en) && $changed(dout_q) |=> $stable(dout_q))
    else $error("Filtered output reversed inside the hold interval.");

endmodule // ccr_zlf

// file: hdl/ccr_top.sv
// Control and status register for one analog comparator channel with pin and timer routing.
// Overview of operation
// - Enable bit 7 switches the comparator on; cleared, it idles at minimum power.
// - With inverted polarity, result bit 6 reads 1 when noninverting input is lower.
// - With normal polarity, result reads 1 when noninverting input is higher.
// - Bit 4 selects whether the result seen by software and logic is inverted.
// - Pin output enable bit 5 routes the result to the pin when direction cleared.
// - Pin routing depends only on pin output enable and direction, not comparator enable.
// - With pin output enable cleared the pin keeps its ordinary port function.
// - Port reads return 0 for every pin configured as analog input.
// - Filter enable bit 3 stops a result change reversing for a short hold.
// - Sync bit 0 latches timer and pin result on timer clock falling edge.
`timescale 1ns/1ps
`include "ccr_consts.svh"

module ccr_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Register port.
  input wire ccr_pkg::ccr_bus_s bus,
  output logic [`CCR_DW-1:0] rdata_q,
  // Analog comparator core.
  input wire logic noninv_above,
  output logic comparator_on,
  output logic speed_select,
  output logic hysteresis_enable,
  // Timer clock source after prescaler and gate output.
  input wire logic timer_clk_src,
  output logic timer_gate_q,
  // Port pin.
  input wire logic pin_direction_bit,
  input wire logic port_latch,
  output logic pin_data_q,
  output logic pin_oe_n_q,
  // Port read path.
  input wire logic [`CCR_DW-1:0] port_pin_level,
  input wire logic [`CCR_DW-1:0] port_analog_select
);
  import ccr_pkg::*;

  function automatic ccr_ctrl_s to_ctrl(input logic [`CCR_DW-1:0] v);
    ccr_ctrl_s c;
    c.en = v[`CCR_BIT_EN];
    c.oe = v[`CCR_BIT_OE];
    c.pol = v[`CCR_BIT_POL];
    c.zlf = v[`CCR_BIT_ZLF];
    c.sp = v[`CCR_BIT_SP];
    c.hys = v[`CCR_BIT_HYS];
    c.sync = v[`CCR_BIT_SYNC];
    return c;
  endfunction

  localparam ccr_ctrl_s CTRL_RST = to_ctrl(`CCR_CTRL_RESET);

  ccr_ctrl_s ctrl_q;
  logic raw_q;
  logic pol_res;
  logic filt_q;
  logic tclk_q;
  logic tclk_fall;
  logic gate_d;
  logic wr_ctrl;
  logic rd_ctrl;
  logic rd_port;

  assign wr_ctrl = bus.wr && (bus.addr == `CCR_OFS_CTRL);
  assign rd_ctrl = bus.rd && (bus.addr == `CCR_OFS_CTRL);
  assign rd_port = bus.rd && (bus.addr == `CCR_OFS_PORT);

  // Control fields; the result bit has no storage, so a write to it is simply lost.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= to_ctrl(bus.wdata);
    end
  end

  assign comparator_on = ctrl_q.en;
  assign speed_select = ctrl_q.sp;
  assign hysteresis_enable = ctrl_q.hys;

  // The comparison is latched every cycle; a powered-down comparator reads as low.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= ctrl_q.en & noninv_above;
    end
  end

  // Inverting the result is the same as swapping the two inputs.
  assign pol_res = raw_q ^ ctrl_q.pol;

  ccr_zlf u_zlf (
    .clk(clk),
    .reset_n(reset_n),
    .filter_en(ctrl_q.zlf),
    .din(pol_res),
    .dout_q(filt_q)
  );

  // Falling edge of the timer clock; the timer counts on the rising edge, so the
  // latched value is settled before the timer looks at it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tclk_q <= 1'b0;
    end else begin
      tclk_q <= timer_clk_src;
    end
  end

  assign tclk_fall = tclk_q & ~timer_clk_src;
  assign gate_d = ctrl_q.sync ? (tclk_fall ? filt_q : timer_gate_q) : filt_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_gate_q <= 1'b0;
    end else begin
      timer_gate_q <= gate_d;
    end
  end

  // Pin override: the comparator enable plays no part in the routing.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_data_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_data_q <= ctrl_q.oe ? gate_d : port_latch;
      pin_oe_n_q <= pin_direction_bit;
    end
  end

  // Read data, valid only in the cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= `CCR_RDATA_RESET;
    end else if (rd_ctrl) begin
      rdata_q <= {ctrl_q.en, filt_q, ctrl_q.oe, ctrl_q.pol,
                  ctrl_q.zlf, ctrl_q.sp, ctrl_q.hys, ctrl_q.sync};
    end else if (rd_port) begin
      rdata_q <= port_pin_level & ~port_analog_select;
    end else begin
      rdata_q <= `CCR_RDATA_RESET;
    end
  end

  // Two-cycle path from input to result with filter off and settings held.
  sequence s_above_plain;
    (ctrl_q.en && !ctrl_q.pol && !ctrl_q.zlf && noninv_above) ##1
      (!ctrl_q.pol && !ctrl_q.zlf);
  endsequence

  sequence s_above_inverted;
    (ctrl_q.en && ctrl_q.pol && !ctrl_q.zlf && noninv_above) ##1
      (ctrl_q.pol && !ctrl_q.zlf);
  endsequence

  sequence s_below_inverted;
    (ctrl_q.en && ctrl_q.pol && !ctrl_q.zlf && !noninv_above) ##1
      (ctrl_q.pol && !ctrl_q.zlf);
  endsequence

  a_off_forces_low: assert property (@(posedge clk) disable iff (!reset_n)
    !ctrl_q.en |=> !raw_q)
    else $error("Disabled comparator produced a high result.");

  a_normal_pol_high: assert property (@(posedge clk) disable iff (!reset_n)
    s_above_plain |=> filt_q)
    else $error("Normal polarity result not high for higher noninverting input.");

  a_inverted_pol_low: assert property (@(posedge clk) disable iff (!reset_n)
    s_above_inverted |=> !filt_q)
    else $error("Inverted polarity result not low for higher noninverting input.");

  a_inverted_pol_high: assert property (@(posedge clk) disable iff (!reset_n)
    s_below_inverted |=> filt_q)
    else $error("Inverted polarity result not high for lower noninverting input.");

  a_pin_gets_result: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_q.oe && !ctrl_q.sync |=> pin_data_q == timer_gate_q)
    else $error("Enabled pin does not carry the comparator result.");

  a_pin_dir_only: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> pin_oe_n_q == $past(pin_direction_bit))
    else $error("Pin drive does not follow the direction bit alone.");

  a_pin_port_func: assert property (@(posedge clk) disable iff (!reset_n)
    !ctrl_q.oe |=> pin_data_q == $past(port_latch))
    else $error("Pin carries comparator result while override is off.");

  a_analog_reads_zero: assert property (@(posedge clk) disable iff (!reset_n)
    rd_port |=> (rdata_q & $past(port_analog_select)) == '0)
    else $error("Analog pin read back as one.");

  a_sync_holds_gate: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl_q.sync && !tclk_fall |=> $stable(timer_gate_q))
    else $error("Synchronised gate changed off the timer falling edge.");

  a_result_readonly: assert property (@(posedge clk) disable iff (!reset_n)
    rd_ctrl |=> rdata_q[`CCR_BIT_RESULT] == $past(filt_q))
    else $error("Result bit does not show the live comparator result.");

endmodule // ccr_top

// file: bench/ccr_top_tb.sv
// Self-checking testbench for the comparator control register block.
`timescale 1ns/1ps
`include "ccr_consts.svh"

module ccr_top_tb;
  import ccr_pkg::*;

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  ccr_bus_s bus = '0;
  logic [`CCR_DW-1:0] rdata_q;
  logic noninv_above = 1'b0;
  logic comparator_on, speed_select, hysteresis_enable;
  logic timer_clk_src = 1'b0;
  logic timer_gate_q;
  logic pin_direction_bit = 1'b1;
  logic port_latch = 1'b0;
  logic pin_data_q, pin_oe_n_q;
  logic [`CCR_DW-1:0] port_pin_level = '0;
  logic [`CCR_DW-1:0] port_analog_select = '0;
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] rnd = 32'h923c7c70;
  logic [7:0] c, d, lvl, an;
  logic na, dir, lat, r;

  ccr_top i_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata_q(rdata_q),
    .noninv_above(noninv_above), .comparator_on(comparator_on),
    .speed_select(speed_select), .hysteresis_enable(hysteresis_enable),
    .timer_clk_src(timer_clk_src), .timer_gate_q(timer_gate_q),
    .pin_direction_bit(pin_direction_bit), .port_latch(port_latch),
    .pin_data_q(pin_data_q), .pin_oe_n_q(pin_oe_n_q),
    .port_pin_level(port_pin_level), .port_analog_select(port_analog_select));

  always #20 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // A disabled comparator reports a raw 0, so only polarity shows through.
  function automatic logic exp_result(input logic en, input logic pol, input logic above);
    return (en & above) ^ pol;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask

  // Read data only stand in the cycle after the strobe, so sample just past that edge.
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 v = rdata_q;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk({comparator_on, speed_select, hysteresis_enable, pin_oe_n_q}, 8'h05, "rst outs");
    rd_reg(`CCR_OFS_CTRL, d);
    chk(d, `CCR_CTRL_RESET, "rst ctrl");
    // Every bit but sync bit 0 written as 1, including the read-only result bit.
    @(posedge clk) noninv_above <= 1'b1;
    wr_reg(`CCR_OFS_CTRL, 8'hfe);
    repeat (4) @(posedge clk);
    rd_reg(`CCR_OFS_CTRL, d);
    chk(d, 8'hbe, "ro result");
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr_next(rnd);
      c = {rnd[7:1], 1'b0};
      {lat, dir, na} = rnd[10:8];
      lvl = rnd[23:16];
      an = rnd[31:24];
      if (i == 0) begin
        c = 8'h20;
      end
      @(posedge clk) begin
        noninv_above <= na;
        pin_direction_bit <= dir;
        port_latch <= lat;
        port_pin_level <= lvl;
        port_analog_select <= an;
      end
      wr_reg(`CCR_OFS_CTRL, c);
      wr_reg(`CCR_OFS_PORT, rnd[15:8]);
      repeat (6) @(posedge clk);
      r = exp_result(c[7], c[4], na);
      rd_reg(`CCR_OFS_CTRL, d);
      chk(d, {c[7], r, c[5:1], 1'b0}, "ctrl");
      chk({comparator_on, speed_select, hysteresis_enable}, {c[7], c[2], c[1]}, "core");
      chk({timer_gate_q, pin_data_q, pin_oe_n_q}, {r, c[5] ? r : lat, dir}, "pin");
      rd_reg(`CCR_OFS_PORT, d);
      chk(d, lvl & ~an, "port");
      rd_reg({2'b11, rnd[13:12]}, d);
      chk(d, 8'h00, "unmapped");
    end
    // Synchronised output only moves on a falling edge of the timer clock.
    @(posedge clk) begin
      noninv_above <= 1'b0;
      timer_clk_src <= 1'b1;
      pin_direction_bit <= 1'b0;
    end
    wr_reg(`CCR_OFS_CTRL, 8'ha1);
    @(posedge clk) timer_clk_src <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({timer_gate_q, pin_data_q}, 8'h00, "sync low");
    @(posedge clk) begin
      noninv_above <= 1'b1;
      timer_clk_src <= 1'b1;
    end
    repeat (6) @(posedge clk);
    #1 chk({timer_gate_q, pin_data_q}, 8'h00, "sync hold");
    @(posedge clk) timer_clk_src <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({timer_gate_q, pin_data_q}, 8'h03, "sync fall");
    tally_and_finish();
  end
endmodule // ccr_top_tb
